// ---- logic/rtctc_pkg.sv ----
/*
  rtctc_pkg: register offsets, field positions, reset values and timing
  constants for the real-time clock timer.
  assumes a 50 MHz system clock and a 32-bit Avalon-MM register bus.
*/
package rtctc_pkg;

  // register word addresses (one 32-bit word each)
  localparam logic [3:0] OFF_SECONDS   = 4'h0;
  localparam logic [3:0] OFF_MINUTES   = 4'h1;
  localparam logic [3:0] OFF_HOURS     = 4'h2;
  localparam logic [3:0] OFF_WEEKDAY   = 4'h3;
  localparam logic [3:0] OFF_CONTROL1  = 4'h4;
  localparam logic [3:0] OFF_CONTROL2  = 4'h5;
  localparam logic [3:0] OFF_SRC_SEL   = 4'h6;
  localparam logic [3:0] OFF_IRQ_CTRL  = 4'h7;

  // rtc_control_first fields
  localparam int BIT_RUN_REQ     = 0;
  localparam int BIT_RUNNING     = 1;
  localparam int BIT_HOUR_FMT    = 2;
  localparam int BIT_AFTERNOON   = 3;
  localparam int BIT_UPD_BUSY    = 4;
  // rtc_irq_control fields
  localparam int BIT_REQ_PENDING = 0;
  localparam int BIT_IRQ_ENABLE  = 1;

  localparam logic [7:0] CONTROL2_RESET = 8'h00;
  localparam logic [3:0] SRC_SEL_RESET  = 4'h0;

  // count-source tick: one second base divided into 256 sub-ticks
  localparam int CLK_HZ          = 50_000_000;
  localparam int SUBTICKS_PER_S  = 256;
  localparam int TICK_CYCLES     = CLK_HZ / SUBTICKS_PER_S;
  // start/stop handshake latency, in count-source ticks
  localparam int HANDSHAKE_TICKS = 2;
  // busy window around each update, microseconds
  localparam int BUSY_US         = 62_500;
  localparam int BUSY_SUBTICKS   = (BUSY_US * SUBTICKS_PER_S) / 1_000_000;

  localparam logic [5:0] SEC_MAX  = 6'd59;
  localparam logic [5:0] MIN_MAX  = 6'd59;
  localparam logic [4:0] HR24_MAX = 5'd23;
  localparam logic [4:0] HR12_MAX = 5'd11;
  localparam logic [2:0] WK_MAX   = 3'd6;

  typedef struct packed {
    logic [5:0] sec;
    logic [5:0] min;
    logic [4:0] hr;
    logic [2:0] wk;
    logic       pm;
  } rtctc_time_t;

endpackage

// ---- logic/rtctc_top.sv ----
/*
  rtctc_top: real-time clock timer with start/stop handshake, time
  registers, update busy flag and update request flag, on Avalon-MM.
  assumes a synchronous active-high reset and a master that honours
  waitrequest; the count source is a divider tick from clk_i.
*/
// The Avalon-MM slave port and the register offsets are this design's own decisions.
// Functional notes
// - start bit raises running flag within two ticks
// - clearing start drops running flag within two ticks
// - stopped means start and running both zero
// - busy held about 62.5 ms around update
// - time reads are not an atomic snapshot
// - each update sets the request pending flag
`timescale 1ns/10ps
module rtctc_top #(
  parameter int TICK_CYCLES = rtctc_pkg::TICK_CYCLES
) (
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic [3:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  output logic             count_running_flag_o,
  output logic             update_in_progress_o
);

  typedef enum logic [1:0] {
    RTCTC_IDLE = 2'b00,
    RTCTC_ACK  = 2'b01
  } rtctc_bus_t;

  rtctc_bus_t          bus_state;
  rtctc_pkg::rtctc_time_t tm;
  logic                count_run_request;
  logic                count_running_flag;
  logic                hour_format_select;
  logic                update_in_progress;
  logic                request_pending_flag;
  logic                irq_enable;
  logic [7:0]          rtc_control_second;
  logic [3:0]          clock_source_bits;
  logic [31:0]         tick_div;
  logic [7:0]          subtick;
  logic [1:0]          hs_cnt;
  logic [7:0]          busy_cnt;

  // count-source tick from divider
  wire logic tick       = (tick_div == 32'(TICK_CYCLES - 1));
  wire logic sec_tick   = tick && (subtick == 8'hff);
  wire logic mismatch   = (count_run_request != count_running_flag);
  wire logic stopped    = !count_run_request && !count_running_flag;
  // a write lands at the edge where the master sees waitrequest low
  wire logic wr_go      = avs_write_i && (bus_state == RTCTC_ACK);
  wire logic rd_go      = avs_read_i && (bus_state == RTCTC_IDLE);
  wire logic lane0      = avs_byteenable_i[0];
  wire logic wr_ctl1    = wr_go && lane0 && (avs_address_i == rtctc_pkg::OFF_CONTROL1);
  wire logic wr_irq     = wr_go && lane0 && (avs_address_i == rtctc_pkg::OFF_IRQ_CTRL);
  // setup registers only take writes while stopped; others are dropped
  wire logic setup_ok   = wr_go && lane0 && stopped;
  wire logic update     = sec_tick && count_running_flag;
  // busy rises seven ticks before the update, falls after it
  wire logic busy_start = count_running_flag && tick &&
                          (subtick == 8'(256 - rtctc_pkg::BUSY_SUBTICKS / 2));
  wire logic hr_wrap    = (tm.hr == (hour_format_select ? rtctc_pkg::HR12_MAX
                                                        : rtctc_pkg::HR24_MAX));
  wire logic day_carry  = hr_wrap && (!hour_format_select || tm.pm);

  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    case (avs_address_i)
      rtctc_pkg::OFF_SECONDS:  rd_mux = {2'b00, tm.sec};
      rtctc_pkg::OFF_MINUTES:  rd_mux = {2'b00, tm.min};
      rtctc_pkg::OFF_HOURS:    rd_mux = {3'b000, tm.hr};
      rtctc_pkg::OFF_WEEKDAY:  rd_mux = {5'b00000, tm.wk};
      rtctc_pkg::OFF_CONTROL1: rd_mux = {3'b000, update_in_progress, tm.pm,
                                         hour_format_select, count_running_flag,
                                         count_run_request};
      rtctc_pkg::OFF_CONTROL2: rd_mux = rtc_control_second;
      rtctc_pkg::OFF_SRC_SEL:  rd_mux = {4'h0, clock_source_bits};
      rtctc_pkg::OFF_IRQ_CTRL: rd_mux = {6'h00, irq_enable, request_pending_flag};
      default:                 rd_mux = 8'h00;
    endcase
  end

  // bus: one wait cycle, then acknowledge
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      bus_state         <= RTCTC_IDLE;
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h0000_0000;
    end else begin
      case (bus_state)
        RTCTC_IDLE: begin
          avs_waitrequest_o <= !(avs_read_i || avs_write_i);
          if (avs_read_i || avs_write_i) begin
            bus_state <= RTCTC_ACK;
          end
          if (rd_go) begin
            avs_readdata_o <= {24'h00_0000, rd_mux};
          end
        end
        RTCTC_ACK: begin
          bus_state         <= RTCTC_IDLE;
          avs_waitrequest_o <= 1'b1;
        end
        default: begin
          bus_state         <= RTCTC_IDLE;
          avs_waitrequest_o <= 1'b1;
        end
      endcase
    end
  end

  // control and configuration registers
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      count_run_request  <= 1'b0;
      hour_format_select <= 1'b0;
      rtc_control_second <= rtctc_pkg::CONTROL2_RESET;
      clock_source_bits  <= rtctc_pkg::SRC_SEL_RESET;
      irq_enable         <= 1'b0;
    end else begin
      if (wr_ctl1) begin
        count_run_request <= avs_writedata_i[rtctc_pkg::BIT_RUN_REQ];
      end
      if (setup_ok && avs_address_i == rtctc_pkg::OFF_CONTROL1) begin
        hour_format_select <= avs_writedata_i[rtctc_pkg::BIT_HOUR_FMT];
      end
      if (setup_ok && avs_address_i == rtctc_pkg::OFF_CONTROL2) begin
        rtc_control_second <= avs_writedata_i[7:0];
      end
      if (setup_ok && avs_address_i == rtctc_pkg::OFF_SRC_SEL) begin
        clock_source_bits <= avs_writedata_i[3:0];
      end
      if (wr_irq) begin
        irq_enable <= avs_writedata_i[rtctc_pkg::BIT_IRQ_ENABLE];
      end
    end
  end

  // count source and start/stop handshake
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      tick_div           <= 32'h0000_0000;
      subtick            <= 8'h00;
      hs_cnt             <= 2'b00;
      count_running_flag <= 1'b0;
    end else begin
      tick_div <= tick ? 32'h0000_0000 : tick_div + 32'h0000_0001;
      if (tick && count_running_flag) begin
        subtick <= subtick + 8'h01;
      end
      if (!mismatch) begin
        hs_cnt <= 2'b00;
      end else if (tick) begin
        if (hs_cnt == 2'(rtctc_pkg::HANDSHAKE_TICKS - 1)) begin
          count_running_flag <= count_run_request;
          hs_cnt             <= 2'b00;
        end else begin
          hs_cnt <= hs_cnt + 2'b01;
        end
      end
    end
  end

  // time counters with carry chain
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      tm <= '0;
    end else if (setup_ok && avs_address_i == rtctc_pkg::OFF_SECONDS) begin
      tm.sec <= avs_writedata_i[5:0];
    end else if (setup_ok && avs_address_i == rtctc_pkg::OFF_MINUTES) begin
      tm.min <= avs_writedata_i[5:0];
    end else if (setup_ok && avs_address_i == rtctc_pkg::OFF_HOURS) begin
      tm.hr <= avs_writedata_i[4:0];
    end else if (setup_ok && avs_address_i == rtctc_pkg::OFF_WEEKDAY) begin
      tm.wk <= avs_writedata_i[2:0];
    end else if (setup_ok && avs_address_i == rtctc_pkg::OFF_CONTROL1) begin
      tm.pm <= avs_writedata_i[rtctc_pkg::BIT_AFTERNOON];
    end else if (update) begin
      tm.sec <= (tm.sec == rtctc_pkg::SEC_MAX) ? 6'd0 : tm.sec + 6'd1;
      if (tm.sec == rtctc_pkg::SEC_MAX) begin
        tm.min <= (tm.min == rtctc_pkg::MIN_MAX) ? 6'd0 : tm.min + 6'd1;
        if (tm.min == rtctc_pkg::MIN_MAX) begin
          tm.hr <= hr_wrap ? 5'd0 : tm.hr + 5'd1;
          if (hr_wrap && hour_format_select) begin
            tm.pm <= !tm.pm;
          end
          if (day_carry) begin
            tm.wk <= (tm.wk == rtctc_pkg::WK_MAX) ? 3'd0 : tm.wk + 3'd1;
          end
        end
      end
    end
  end

  // busy window and update request; set wins over clear
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      update_in_progress   <= 1'b0;
      busy_cnt             <= 8'h00;
      request_pending_flag <= 1'b0;
    end else begin
      if (busy_start) begin
        update_in_progress <= 1'b1;
        busy_cnt           <= 8'h00;
      end else if (update_in_progress && tick) begin
        busy_cnt <= busy_cnt + 8'h01;
        if (busy_cnt == 8'(rtctc_pkg::BUSY_SUBTICKS - 1)) begin
          update_in_progress <= 1'b0;
        end
      end
      if (!count_running_flag) begin
        update_in_progress <= 1'b0;
      end
      if (update) begin
        request_pending_flag <= 1'b1;
      end else if (wr_irq && !avs_writedata_i[rtctc_pkg::BIT_REQ_PENDING]) begin
        request_pending_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      count_running_flag_o <= 1'b0;
      update_in_progress_o <= 1'b0;
    end else begin
      count_running_flag_o <= count_running_flag;
      update_in_progress_o <= update_in_progress;
    end
  end

endmodule

// ---- bench/rtctc_chk.sv ----
/* rtctc_chk: bus and flag timing checks on rtctc_top ports.
   assumes the bind hands on the tick length used by the design. */
`timescale 1ns/10ps
module rtctc_chk #(
  parameter int TICK_CYCLES = 4
) (
  input wire logic        clk_i,
  input wire logic        reset_i,
  input wire logic [3:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0]  avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  input wire logic        count_running_flag_o,
  input wire logic        update_in_progress_o
);
  // two ticks plus tick phase and the output register
  localparam int SPAN = 3 * TICK_CYCLES + 3;
  int unsigned busy_len;
  wire ctl_wr = avs_write_i && !avs_waitrequest_o && avs_address_i == 4'h4
                && avs_byteenable_i[0];
  always_ff @(posedge clk_i) begin
    if (reset_i || !update_in_progress_o) begin
      busy_len <= 0;
    end else begin
      busy_len <= busy_len + 1;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  wait_pulse_a: assert property ($fell(avs_waitrequest_o) |=> avs_waitrequest_o)
    else $error("waitrequest low too long");
  wait_cause_a: assert property (!avs_waitrequest_o |-> $past(avs_read_i) || $past(avs_write_i))
    else $error("completion without request");
  answer_time_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |-> ##[1:2] !avs_waitrequest_o) else $error("bus answer late");
  high_zero_a: assert property (avs_readdata_o[31:8] == 24'h00_0000)
    else $error("read data upper bits set");
  data_hold_a: assert property ($changed(avs_readdata_o) |-> !avs_waitrequest_o)
    else $error("read data moved outside a read");
  start_flag_a: assert property (ctl_wr && avs_writedata_i[0] && !count_running_flag_o
    |-> ##[1:SPAN] count_running_flag_o) else $error("running flag did not rise");
  stop_flag_a: assert property (ctl_wr && !avs_writedata_i[0] && count_running_flag_o
    |-> ##[1:SPAN] !count_running_flag_o) else $error("running flag did not fall");
  busy_span_a: assert property ($fell(update_in_progress_o)
    |-> busy_len == 16 * TICK_CYCLES) else $error("busy window wrong length");
endmodule
bind rtctc_top rtctc_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.clk_i(clk_i), .reset_i(reset_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .count_running_flag_o(count_running_flag_o), .update_in_progress_o(update_in_progress_o));

// ---- bench/rtctc_top_tb_top.sv ----
/* rtctc_top_tb_top: register-level tests of the real-time clock timer.
   assumes a tick of 4 clocks, so one second is 1024 clocks. */
`timescale 1ns/10ps
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin err_count++; \
  $display("unexpected %s exp %h got %h", n, e, s); end end
module rtctc_top_tb_top;
  localparam int TK = 4;
  localparam logic [3:0] SA [7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h6, 4'h7, 4'h5};
  localparam logic [7:0] SV [7] = '{8'h3a, 8'h3b, 8'h17, 8'h06, 8'h0f, 8'h02, 8'ha5};
  logic        clk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic [3:0]  avs_address_i = 4'h0;
  logic        avs_read_i = 1'b0;
  logic        avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0000_0000;
  logic [3:0]  avs_byteenable_i = 4'hf;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic        count_running_flag_o;
  logic        update_in_progress_o;
  logic [31:0] rd;
  int          err_count = 0;
  int          comparisons = 0;
  int          n;
  always #10 clk_i = ~clk_i;
  rtctc_top #(.TICK_CYCLES(TK)) u_dut (.clk_i(clk_i), .reset_i(reset_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .count_running_flag_o(count_running_flag_o), .update_in_progress_o(update_in_progress_o));
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= {24'h00_0000, d};
    avs_write_i <= wr;
    avs_read_i <= !wr;
    do begin
      @(posedge clk_i);
      k++;
    end while (avs_waitrequest_o !== 1'b0 && k < 50);
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    `CHK("bus answer", 1'b1, k < 50)
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    `CHK("register", {24'h00_0000, e}, rd)
  endtask
  task automatic wait_for(ref logic s, input logic v);
    n = 0;
    while (s !== v && n < 3000) begin
      @(posedge clk_i);
      n++;
    end
  endtask
  task automatic wait_pending();
    int k;
    k = 0;
    rd = 32'h0000_0000;
    while (rd[0] !== 1'b1 && k < 2000) begin
      bus(1'b0, 4'h7, 8'h00);
      k++;
    end
  endtask
  task automatic test_done();
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    // all registers clear, index 8 unmapped
    for (int i = 0; i < 9; i++) rdchk(4'(i), 8'h00);
    bus(1'b1, 4'h8, 8'hff);
    rdchk(4'h8, 8'h00);
    // control two written last before the start
    for (int i = 0; i < 7; i++) bus(1'b1, SA[i], SV[i]);
    for (int i = 0; i < 7; i++) rdchk(SA[i], SV[i]);
    avs_byteenable_i <= 4'he;
    bus(1'b1, 4'h0, 8'h11);
    avs_byteenable_i <= 4'hf;
    rdchk(4'h0, 8'h3a);
    // only the port flag is watched until it follows
    bus(1'b1, 4'h4, 8'h01);
    wait_for(count_running_flag_o, 1'b1);
    `CHK("start delay", 1'b1, n <= 3 * TK + 3)
    rdchk(4'h4, 8'h03);
    bus(1'b1, 4'h0, 8'h05);
    rdchk(4'h0, 8'h3a);
    wait_pending();
    `CHK("pending", 1'b1, rd[0])
    rdchk(4'h0, 8'h3b);
    bus(1'b1, 4'h7, 8'h02);
    rdchk(4'h7, 8'h02);
    wait_for(update_in_progress_o, 1'b0);
    wait_for(update_in_progress_o, 1'b1);
    `CHK("busy rise", 1'b1, update_in_progress_o)
    wait_for(update_in_progress_o, 1'b0);
    `CHK("busy fall", 1'b0, update_in_progress_o)
    // back to back reads after the busy window: every carry wrapped
    for (int i = 0; i < 4; i++) rdchk(4'(i), 8'h00);
    rdchk(4'h0, 8'h00);
    bus(1'b1, 4'h4, 8'h00);
    wait_for(count_running_flag_o, 1'b0);
    `CHK("stop delay", 1'b1, n <= 3 * TK + 3)
    rdchk(4'h4, 8'h00);
    // 12-hour mode, 11:59:59 in the afternoon
    bus(1'b1, 4'h0, 8'h3b);
    bus(1'b1, 4'h1, 8'h3b);
    bus(1'b1, 4'h2, 8'h0b);
    // drop the request left by the last rollover so only the new one counts
    bus(1'b1, 4'h7, 8'h02);
    rdchk(4'h7, 8'h02);
    bus(1'b1, 4'h4, 8'h0c);
    bus(1'b1, 4'h4, 8'h0d);
    wait_for(count_running_flag_o, 1'b1);
    wait_pending();
    rdchk(4'h2, 8'h00);
    rdchk(4'h3, 8'h01);
    bus(1'b0, 4'h4, 8'h00);
    `CHK("afternoon", 4'h7, rd[3:0])
    test_done();
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    test_done();
  end
endmodule
